// ==== logic/bba_pkg.sv ====
package bba_pkg;
    localparam logic [15:0] SADDR_LO = 16'hfe20;
    localparam logic [15:0] SADDR_HI = 16'hff1f;
    localparam logic [7:0] ADJ_HI = 8'h60;
    localparam logic [7:0] ADJ_LO = 8'h06;
    localparam logic [7:0] ADJ_BOTH = 8'h66;
    localparam int PSW_CY = 0;
    localparam int PSW_AC = 4;
    localparam int PSW_Z = 6;
    localparam logic [7:0] PSW_RST = 8'h00;
    localparam logic [7:0] REG_RST = 8'h00;

    typedef enum logic [2:0] {
        BBA_NOP = 3'b000,
        BBA_ADJ = 3'b001,
        BBA_MOV_TO_CY = 3'b010,
        BBA_MOV_FROM_CY = 3'b011,
        BBA_AND = 3'b100,
        BBA_OR = 3'b101
    } bba_op_e;

    typedef enum logic [2:0] {
        BBA_SRC_SADDR = 3'b000,
        BBA_SRC_SFR = 3'b001,
        BBA_SRC_A = 3'b010,
        BBA_SRC_X = 3'b011,
        BBA_SRC_PSW = 3'b100
    } bba_src_e;

    typedef struct packed {
        bba_op_e op;
        bba_src_e src;
        logic invert;
        logic [2:0] bit_idx;
        logic [15:0] saddr;
    } bba_cmd_s;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [7:0] data;
    } bba_mem_wr_s;
endpackage

// ==== logic/bba_unit.sv ====
`timescale 1ns/1ps
module bba_unit (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire bba_pkg::bba_cmd_s cmd,
    input wire logic [7:0] saddr_rdata,
    input wire logic [7:0] sfr_rdata,
    output bba_pkg::bba_mem_wr_s saddr_wr,
    output bba_pkg::bba_mem_wr_s sfr_wr,
    output logic [7:0] acc,
    output logic [7:0] reg_x,
    output logic [7:0] program_status_word,
    output logic saddr_range_err
);
    import bba_pkg::*;

    function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] i,
                                           input logic b);
        logic [7:0] r;
        r = v;
        r[i] = b;
        return r;
    endfunction

    wire logic cy = program_status_word[PSW_CY];
    wire logic go = cmd_valid;
    wire logic saddr_ok = (cmd.saddr >= SADDR_LO) && (cmd.saddr <= SADDR_HI);
    // Out of range short address: operation other than adjust dropped, flag raised
    wire logic src_bad = (cmd.src == BBA_SRC_SADDR) && !saddr_ok;

    // Source byte; PROGRAM_STATUS_WORD carries Z at bit 6 so Z is read directly
    wire logic [7:0] src_byte = (cmd.src == BBA_SRC_SADDR) ? saddr_rdata :
                                (cmd.src == BBA_SRC_SFR) ? sfr_rdata :
                                (cmd.src == BBA_SRC_A) ? acc :
                                (cmd.src == BBA_SRC_X) ? reg_x : program_status_word;
    wire logic sel_bit = src_byte[cmd.bit_idx];
    wire logic opnd = sel_bit ^ cmd.invert;

    wire logic [7:0] adj_val = program_status_word[PSW_AC] ? (cy ? ADJ_BOTH : ADJ_LO) :
                               (cy ? ADJ_HI : 8'h00);
    wire logic [7:0] adj_res = acc - adj_val;
    // Carry keeps its previous value through the adjust; borrow out is not used
    wire logic adj_cy = cy;
    wire logic adj_ac = program_status_word[PSW_AC] && (acc[3:0] < adj_val[3:0]);

    wire logic is_adj = go && cmd.op == BBA_ADJ;
    wire logic is_to = go && !src_bad && cmd.op == BBA_MOV_TO_CY;
    wire logic is_from = go && !src_bad && cmd.op == BBA_MOV_FROM_CY;
    wire logic is_and = go && !src_bad && cmd.op == BBA_AND;
    wire logic is_or = go && !src_bad && cmd.op == BBA_OR;

    wire logic next_cy = is_to ? sel_bit :
                         is_and ? (cy & opnd) :
                         is_or ? (cy | opnd) :
                         is_adj ? adj_cy : cy;
    wire logic [7:0] put_val = put_bit(src_byte, cmd.bit_idx, cy);
    wire logic wr_a = is_from && cmd.src == BBA_SRC_A;
    wire logic wr_x = is_from && cmd.src == BBA_SRC_X;
    wire logic wr_psw = is_from && cmd.src == BBA_SRC_PSW;

    wire logic [7:0] next_psw_adj = put_bit(put_bit(put_bit(program_status_word, 3'(PSW_Z), adj_res == 8'h00),
                                    3'(PSW_AC), adj_ac), 3'(PSW_CY), adj_cy);
    // Only carry moves for AND, OR, move to carry
    wire logic [7:0] next_psw = wr_psw ? put_val :
                                is_adj ? next_psw_adj :
                                put_bit(program_status_word, 3'(PSW_CY), next_cy);

    wire logic [7:0] next_acc = is_adj ? adj_res : (wr_a ? put_val : acc);
    wire logic [7:0] next_x = wr_x ? put_val : reg_x;
    // Whole byte goes back; caller must forward it to later reads
    wire bba_mem_wr_s next_saddr_wr = '{valid: is_from && cmd.src == BBA_SRC_SADDR,
                                        addr: cmd.saddr, data: put_val};
    wire bba_mem_wr_s next_sfr_wr = '{valid: is_from && cmd.src == BBA_SRC_SFR,
                                      addr: cmd.saddr, data: put_val};
    wire logic next_range_err = go && src_bad && cmd.op != BBA_ADJ;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            program_status_word <= PSW_RST;
        end else begin
            program_status_word <= next_psw;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc <= REG_RST;
        end else begin
            acc <= next_acc;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_x <= REG_RST;
        end else begin
            reg_x <= next_x;
        end
    end

    // Write strobes are one cycle pulses, never held
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            saddr_wr <= '0;
        end else begin
            saddr_wr <= next_saddr_wr;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sfr_wr <= '0;
        end else begin
            sfr_wr <= next_sfr_wr;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            saddr_range_err <= 1'b0;
        end else begin
            saddr_range_err <= next_range_err;
        end
    end

    // Read-modify-write of a short direct byte
    sequence saddr_from_seq;
        is_from && cmd.src == BBA_SRC_SADDR;
    endsequence
    // Read-modify-write of a special function register
    sequence sfr_from_seq;
        is_from && cmd.src == BBA_SRC_SFR;
    endsequence

    adj_table_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        is_adj |=> acc == $past(acc) - $past(adj_val))
        else $error("adjust result wrong");
    and_cy_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        is_and |=> program_status_word[PSW_CY] == ($past(cy) & $past(opnd)))
        else $error("and carry wrong");
    or_cy_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        is_or |=> program_status_word[PSW_CY] == ($past(cy) | $past(opnd)))
        else $error("or carry wrong");
    move_cy_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        is_to |=> program_status_word[PSW_CY] == $past(sel_bit))
        else $error("move to carry wrong");
    flags_kept_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (is_to || is_and || is_or) |=> program_status_word[7:1] == $past(program_status_word[7:1]))
        else $error("other flags changed");
    mem_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (is_from && cmd.src == BBA_SRC_SADDR) |=> saddr_wr.valid
        && saddr_wr.data[$past(cmd.bit_idx)] == $past(cy) && program_status_word == $past(program_status_word))
        else $error("memory bit write wrong");
    acc_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_a |=> acc == put_bit($past(acc), $past(cmd.bit_idx), $past(cy)))
        else $error("acc bit write wrong");
    adj_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        is_adj |=> program_status_word[PSW_Z] == (acc == 8'h00))
        else $error("adjust zero flag wrong");

    and_inv_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (is_and && cmd.invert && cmd.src == BBA_SRC_SADDR)
        |=> program_status_word[PSW_CY] == ($past(cy) & !$past(sel_bit)))
        else $error("inverted and carry wrong");
    and_reg_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (is_and && !cmd.invert && cmd.src != BBA_SRC_SADDR)
        |=> program_status_word[PSW_CY] == ($past(cy) & $past(sel_bit)))
        else $error("register and carry wrong");
    and_reg_inv_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (is_and && cmd.invert && cmd.src != BBA_SRC_SADDR)
        |=> program_status_word[PSW_CY] == ($past(cy) & !$past(sel_bit)))
        else $error("register inverted and wrong");
    or_inv_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (is_or && cmd.invert && cmd.src == BBA_SRC_SADDR)
        |=> program_status_word[PSW_CY] == ($past(cy) | !$past(sel_bit)))
        else $error("inverted or carry wrong");
    or_reg_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (is_or && !cmd.invert && cmd.src != BBA_SRC_SADDR)
        |=> program_status_word[PSW_CY] == ($past(cy) | $past(sel_bit)))
        else $error("register or carry wrong");
    or_reg_inv_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (is_or && cmd.invert && cmd.src != BBA_SRC_SADDR)
        |=> program_status_word[PSW_CY] == ($past(cy) | !$past(sel_bit)))
        else $error("register inverted or wrong");
    move_reg_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (is_to && cmd.src != BBA_SRC_SADDR) |=> program_status_word[PSW_CY] == $past(sel_bit))
        else $error("register move to carry wrong");
    psw_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (is_to && cmd.src == BBA_SRC_PSW && cmd.bit_idx == 3'(PSW_Z))
        |=> program_status_word[PSW_CY] == $past(program_status_word[PSW_Z]))
        else $error("zero flag bit not read");

    // Only the addressed bit may differ from the byte read
    mem_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        saddr_from_seq |=> ((saddr_wr.data ^ $past(saddr_rdata))
        & ~(8'h01 << $past(cmd.bit_idx))) == 8'h00)
        else $error("memory byte bits disturbed");
    sfr_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sfr_from_seq |=> sfr_wr.valid && program_status_word == $past(program_status_word) && sfr_wr.data
        == put_bit($past(sfr_rdata), $past(cmd.bit_idx), $past(cy)))
        else $error("sfr bit write wrong");
    sfr_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !(is_from && cmd.src == BBA_SRC_SFR) |=> !sfr_wr.valid)
        else $error("stray sfr write");
    x_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_x |=> reg_x == put_bit($past(reg_x), $past(cmd.bit_idx), $past(cy)))
        else $error("x bit write wrong");
    x_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !wr_x |=> reg_x == $past(reg_x))
        else $error("x changed unasked");
    acc_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!wr_a && !is_adj) |=> acc == $past(acc))
        else $error("acc changed unasked");
    range_drop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (go && src_bad && cmd.op != BBA_ADJ)
        |=> saddr_range_err && program_status_word == $past(program_status_word) && !saddr_wr.valid)
        else $error("out of range op not dropped");
    adj_carry_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        is_adj |=> program_status_word[PSW_CY] == $past(cy) && program_status_word[PSW_AC] == $past(adj_ac))
        else $error("adjust carry flags wrong");
    idle_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !go |=> program_status_word == $past(program_status_word) && acc == $past(acc) && !saddr_range_err)
        else $error("state moved while idle");
    from_flags_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (is_from && cmd.src != BBA_SRC_PSW) |=> program_status_word == $past(program_status_word))
        else $error("move from carry changed flags");
endmodule // bba_unit

// ==== sim/bba_mem_model.sv ====
`timescale 1ns/1ps
module bba_mem_model (
    input wire logic ref_clk,
    input wire bba_pkg::bba_cmd_s cmd,
    input wire bba_pkg::bba_mem_wr_s saddr_wr,
    output logic [7:0] saddr_rdata,
    output logic [7:0] sfr_rdata
);
    import bba_pkg::*;
    logic [7:0] mem [256];
    // Byte holds its own low address, so every bit is predictable
    initial foreach (mem[i]) mem[i] = 8'(i);
    assign saddr_rdata = mem[cmd.saddr[7:0]];
    assign sfr_rdata = ~saddr_rdata;
    always @(posedge ref_clk) if (saddr_wr.valid) mem[saddr_wr.addr[7:0]] <= saddr_wr.data;
endmodule // bba_mem_model

// ==== sim/test_bba_unit.sv ====
`timescale 1ns/1ps
module test_bba_unit;
    import bba_pkg::*;
    logic ref_clk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, saddr_range_err;
    bba_cmd_s cmd = '0;
    logic [7:0] saddr_rdata, sfr_rdata, acc, reg_x, program_status_word;
    bba_mem_wr_s saddr_wr, sfr_wr;
    int n_fail = 0, comparisons = 0, cycles = 0;
    always #12.5 ref_clk = ~ref_clk;
    bba_unit dut (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .cmd_valid(cmd_valid),
        .cmd(cmd),
        .saddr_rdata(saddr_rdata),
        .sfr_rdata(sfr_rdata),
        .saddr_wr(saddr_wr),
        .sfr_wr(sfr_wr),
        .acc(acc),
        .reg_x(reg_x),
        .program_status_word(program_status_word),
        .saddr_range_err(saddr_range_err)
    );
    bba_mem_model far (
        .ref_clk(ref_clk),
        .cmd(cmd),
        .saddr_wr(saddr_wr),
        .saddr_rdata(saddr_rdata),
        .sfr_rdata(sfr_rdata)
    );
    task automatic chk(logic ok, string what);
        comparisons++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    // Idle cycle after each op lets the memory write land before the next read
    task automatic run(bba_op_e o, bba_src_e s = BBA_SRC_A, logic i = 1'b0,
                       logic [2:0] b = 3'd0, logic [15:0] a = 16'hfe20);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd <= '{o, s, i, b, a};
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        #1;
    endtask
    task automatic carry_op(bba_op_e o, bba_src_e s, logic i, logic [2:0] b, logic e,
                            logic [15:0] a = 16'hfe20);
        logic [7:0] p;
        p = program_status_word;
        run(o, s, i, b, a);
        chk(program_status_word[0] === e, "carry");
        chk(program_status_word[7:1] === p[7:1], "other flags");
    endtask
    task automatic t_zero;
        chk(program_status_word === PSW_RST && acc === REG_RST, "reset");
        run(BBA_ADJ);
        chk(acc === 8'h00 && program_status_word[6] === 1'b1, "adjust zero");
        carry_op(BBA_MOV_TO_CY, BBA_SRC_PSW, 1'b0, 3'd6, 1'b1);
    endtask
    task automatic t_saddr;
        carry_op(BBA_AND, BBA_SRC_SADDR, 1'b1, 3'd5, 1'b0);
        carry_op(BBA_OR, BBA_SRC_SADDR, 1'b0, 3'd5, 1'b1);
        carry_op(BBA_AND, BBA_SRC_SADDR, 1'b1, 3'd5, 1'b0);
        carry_op(BBA_OR, BBA_SRC_SADDR, 1'b1, 3'd0, 1'b1);
        carry_op(BBA_AND, BBA_SRC_SADDR, 1'b0, 3'd0, 1'b0);
        carry_op(BBA_MOV_TO_CY, BBA_SRC_SADDR, 1'b0, 3'd0, 1'b1, 16'hff1f);
    endtask
    task automatic t_move;
        run(BBA_MOV_FROM_CY, BBA_SRC_A, 1'b0, 3'd3);
        chk(acc === 8'h08 && program_status_word[0] === 1'b1, "acc bit");
        run(BBA_MOV_FROM_CY, BBA_SRC_SADDR, 1'b0, 3'd7, 16'hfe21);
        chk(saddr_wr === {1'b1, 16'hfe21, 8'ha1}, "byte write");
        run(BBA_MOV_TO_CY, BBA_SRC_SADDR, 1'b0, 3'd5, 16'hfe1f);
        chk(saddr_range_err === 1'b1 && program_status_word[0] === 1'b1, "range");
    endtask
    task automatic t_regs;
        carry_op(BBA_AND, BBA_SRC_A, 1'b1, 3'd3, 1'b0);
        carry_op(BBA_OR, BBA_SRC_A, 1'b0, 3'd3, 1'b1);
        carry_op(BBA_AND, BBA_SRC_X, 1'b0, 3'd0, 1'b0);
        carry_op(BBA_OR, BBA_SRC_A, 1'b1, 3'd3, 1'b0);
        carry_op(BBA_OR, BBA_SRC_A, 1'b0, 3'd3, 1'b1);
    endtask
    task automatic t_adjust;
        run(BBA_ADJ);
        chk(acc === 8'ha8, "minus 60");
        run(BBA_MOV_FROM_CY, BBA_SRC_PSW, 1'b0, 3'd4);
        run(BBA_ADJ);
        chk(acc === 8'h42 && program_status_word[0] === 1'b1, "minus 66");
        run(BBA_MOV_FROM_CY, BBA_SRC_PSW, 1'b0, 3'd4);
        run(BBA_MOV_TO_CY, BBA_SRC_X);
        run(BBA_ADJ);
        chk(acc === 8'h3c, "minus 06");
    endtask
    // SFR byte at fe20 reads as 8'hdf in the model
    task automatic t_sfr;
        carry_op(BBA_MOV_TO_CY, BBA_SRC_SFR, 1'b0, 3'd0, 1'b1);
        carry_op(BBA_AND, BBA_SRC_SFR, 1'b1, 3'd5, 1'b1);
        carry_op(BBA_OR, BBA_SRC_SFR, 1'b1, 3'd0, 1'b1);
        run(BBA_MOV_FROM_CY, BBA_SRC_SFR, 1'b0, 3'd5);
        chk(sfr_wr === {1'b1, 16'hfe20, 8'hff} && saddr_wr.valid === 1'b0, "sfr write");
        run(BBA_MOV_FROM_CY, BBA_SRC_X, 1'b0, 3'd7);
        chk(reg_x === 8'h80 && sfr_wr.valid === 1'b0, "x bit");
        carry_op(BBA_AND, BBA_SRC_SFR, 1'b0, 3'd5, 1'b0);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_zero();
        t_saddr();
        t_move();
        t_regs();
        t_adjust();
        t_sfr();
        give_verdict();
    end
endmodule // test_bba_unit
